// ===== inc/eslm_pkg.sv
// package: constants, enums and helpers for the engine speed limiter menu
package eslm_pkg;
  // ************************************************************
  // limits and encodings
  // ************************************************************
  localparam logic [9:0] LIM_STEP_RPM    = 10'h064;   // 100 rpm per step
  localparam logic [9:0] LIM_MIN_STEPS   = 10'h00A;   // 1000 rpm
  localparam logic [9:0] LIM_MAX_STEPS   = 10'h257;   // 59900 rpm
  localparam logic [9:0] LIM_RESET_STEPS = 10'h257;   // factory 59900 rpm
  localparam logic [5:0] ANG_MAX_DEG     = 6'h27;     // 39 degrees
  localparam logic       CUT_SUPPRESS    = 1'b0;
  localparam logic       CUT_ANGLE       = 1'b1;
  localparam logic [3:0] TTHOU_LAST      = 4'h5;
  localparam logic [3:0] DIGIT_LAST      = 4'h9;
  localparam logic [3:0] TENS_NO_CODE    = 4'hF;      // 'no' candidate of tens position
  localparam logic [3:0] BLANK_CODE      = 4'hE;
  // display glyph codes in the high nibble pair
  localparam logic [7:0] GLYPH_DIGIT     = 8'h00;
  localparam logic [7:0] GLYPH_PROMPT    = 8'hA1;     // input prompt
  localparam logic [7:0] GLYPH_SEL_LIM   = 8'hA2;     // speed limit option
  localparam logic [7:0] GLYPH_SEL_ANG   = 8'hA3;     // cut-off angle option
  localparam logic [7:0] GLYPH_NO        = 8'hA4;     // suppression
  localparam logic [7:0] GLYPH_ERROR     = 8'hA5;     // entry error indication
  localparam logic [7:0] GLYPH_STORED    = 8'hA6;     // stored confirmation
  localparam logic [7:0] GLYPH_SPEED     = 8'hA7;     // normal operation
  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned CLK_HZ     = 40_000_000;
  localparam int unsigned STEP_MS    = 3000;          // 3 s per shown option
  localparam int unsigned STEP_TICKS = (CLK_HZ / 1000) * STEP_MS;

  typedef enum {
    ESLM_NORMAL, ESLM_SHOW_LIM, ESLM_SHOW_ANG, ESLM_PROMPT, ESLM_PICK,
    ESLM_D_TTH, ESLM_D_TH, ESLM_D_H, ESLM_PICK2, ESLM_A_TENS, ESLM_A_UNIT,
    ESLM_CHECK, ESLM_ERROR, ESLM_RES_LIM, ESLM_RES_ANG, ESLM_STORED
  } eslm_state_e;

  // wrap-around candidate counter
  function automatic logic [3:0] eslm_next_digit(input logic [3:0] d, input logic [3:0] last);
    eslm_next_digit = (d == last) ? 4'h0 : d + 4'h1;
  endfunction

  // limit steps from three entered digits
  function automatic logic [9:0] eslm_steps(input logic [3:0] a, input logic [3:0] b,
                                            input logic [3:0] c);
    eslm_steps = 10'(a) * 10'h064 + 10'(b) * 10'h00A + 10'(c);
  endfunction
endpackage

// ===== inc/eslm_tick_if.sv
// interface: timing tick and step restart between menu and its timer
`timescale 1ns/1ps
interface eslm_tick_if;
  logic restart;
  logic tick;
  modport timer (input restart, output tick);
  modport menu  (output restart, input tick);
endinterface

// ===== sim/eslm_monitor.sv
// checker: port-level assertions for the speed limiter menu
`timescale 1ns/1ps
module eslm_monitor
  import eslm_pkg::*;
#(
  parameter int unsigned PW = 24
) (
  input wire logic          SYS_CLK,
  input wire logic          ARST_N,
  input wire logic          CE,
  input wire logic          MENU_ENTER,
  input wire logic          REV_PULSE,
  input wire logic [PW-1:0] PERIOD,
  input wire logic [PW-1:0] LIMIT_PERIOD,
  input wire logic [9:0]    SPEED_LIMIT_VALUE,
  input wire logic          CUT_MODE,
  input wire logic [5:0]    CUT_ANGLE_DEG,
  input wire logic          SPARK_INHIBIT,
  input wire logic          FORCE_ANGLE,
  input wire logic          ARMED,
  input wire logic [7:0]    DISP_GLYPH,
  input wire logic          ENTRY_ERROR_INDICATION,
  input wire logic          STORE_STROBE
);
  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);
  // over-speed seen at a revolution, mode held while the decision settles
  sequence s_over(m);
    REV_PULSE && CE && PERIOD < LIMIT_PERIOD && CUT_MODE == m
      ##1 (!REV_PULSE && CE && CUT_MODE == m)[*3];
  endsequence
  a_limit_range: assert property (
    SPEED_LIMIT_VALUE >= LIM_MIN_STEPS && SPEED_LIMIT_VALUE <= LIM_MAX_STEPS)
    else $error("stored limit out of range");
  a_angle_range: assert property (
    CUT_ANGLE_DEG <= ANG_MAX_DEG) else $error("cut angle above maximum");
  a_reset_values: assert property (
    $rose(ARST_N) |-> SPEED_LIMIT_VALUE == LIM_RESET_STEPS && CUT_MODE == CUT_SUPPRESS)
    else $error("wrong settings after reset");
  a_suppress_sparks: assert property (
    s_over(CUT_SUPPRESS) |-> SPARK_INHIBIT && !FORCE_ANGLE) else $error("no spark inhibit");
  a_force_angle: assert property (
    s_over(CUT_ANGLE) |-> FORCE_ANGLE && !SPARK_INHIBIT) else $error("no forced angle");
  a_under_limit_free: assert property (
    REV_PULSE && CE && PERIOD >= LIMIT_PERIOD ##1 (!REV_PULSE && CE)[*3]
      |-> !SPARK_INHIBIT && !FORCE_ANGLE) else $error("cut-off below limit");
  a_strobe_single: assert property (
    STORE_STROBE |=> !STORE_STROBE) else $error("store strobe longer than one cycle");
  a_error_no_store: assert property (
    ENTRY_ERROR_INDICATION |-> !STORE_STROBE) else $error("store during error display");
  a_limit_only_stored: assert property (
    $changed(SPEED_LIMIT_VALUE) |-> (STORE_STROBE || $past(STORE_STROBE))
      or (##[1:2] STORE_STROBE)) else $error("limit changed without store");
  a_menu_disarms: assert property (
    ARMED && MENU_ENTER && CE |-> ##[1:2] !ARMED) else $error("menu entry not taken");
  a_normal_holds: assert property (
    ARMED && !MENU_ENTER && !$past(MENU_ENTER) |=> ARMED) else $error("left normal unasked");
  a_error_glyph: assert property (
    $rose(ENTRY_ERROR_INDICATION) |-> ##[0:1] DISP_GLYPH == GLYPH_ERROR)
    else $error("error shown without its glyph");
  a_ce_freeze: assert property (
    !CE |=> $stable(DISP_GLYPH) && $stable(ARMED)) else $error("moved while disabled");
  // main scenarios reached
  c_store: cover property (STORE_STROBE);
  c_error: cover property ($rose(ENTRY_ERROR_INDICATION));
  c_inhibit: cover property (SPARK_INHIBIT);
  c_force: cover property (FORCE_ANGLE);
endmodule

bind eslm_top eslm_monitor #(.PW(PW)) u_mon (
  .SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .CE(CE), .MENU_ENTER(MENU_ENTER),
  .REV_PULSE(REV_PULSE), .PERIOD(PERIOD), .LIMIT_PERIOD(LIMIT_PERIOD),
  .SPEED_LIMIT_VALUE(SPEED_LIMIT_VALUE), .CUT_MODE(CUT_MODE), .CUT_ANGLE_DEG(CUT_ANGLE_DEG),
  .SPARK_INHIBIT(SPARK_INHIBIT), .FORCE_ANGLE(FORCE_ANGLE), .ARMED(ARMED),
  .DISP_GLYPH(DISP_GLYPH), .ENTRY_ERROR_INDICATION(ENTRY_ERROR_INDICATION),
  .STORE_STROBE(STORE_STROBE)
);

// ===== sim/eslm_partner.sv
// model of the operator with magnet switch and of the ignition timing side
`timescale 1ns/1ps
module eslm_partner
  import eslm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [9:0]  lim,
  input  wire logic [7:0]  glyph,
  input  wire logic [3:0]  digit,
  input  wire logic        flash,
  output logic             menu_enter,
  output logic             sw_pulse,
  output logic [23:0]      limit_period
);
  // ************************************************************
  // operator and ignition side
  // ************************************************************
  // ignition side: period at the limit speed, 600000 ticks divided by the limit in 100 rpm steps
  always_comb limit_period = 24'(24'h0927C0 / {14'h0, lim});

  initial begin
    menu_enter = 1'b0;
    sw_pulse   = 1'b0;
  end

  // open the menu with a one-cycle menu_enter pulse
  task automatic enter();
    @(posedge clk);
    #2 menu_enter = 1'b1;
    @(posedge clk);
    #2 menu_enter = 1'b0;
  endtask

  // wait for the wanted option to start flashing, then actuate once;
  // acting at the start of an option keeps clear of its step edge, 16 cycles later in this bench
  task automatic act(input logic [7:0] g, input logic [3:0] d);
    int   n;
    logic hit;
    logic was;
    was = 1'b0;
    for (n = 0; n < 4000; n++) begin
      @(posedge clk);
      #1 hit = flash && glyph == g && (g != GLYPH_DIGIT || digit == d);
      if (hit && !was) break;
      was = hit;
    end
    #1 sw_pulse = 1'b1;
    @(posedge clk);
    #2 sw_pulse = 1'b0;
  endtask
endmodule

// ===== sim/tb.sv
// self-checking bench for the speed limiter menu
`timescale 1ns/1ps
module tb;
  import eslm_pkg::*;
  logic        clk, arst_n, ce, menu_enter, sw_pulse, rev_pulse;
  logic [23:0] period, limit_period;
  logic [9:0]  lim;
  logic [5:0]  cut_ang;
  logic [7:0]  glyph;
  logic [3:0]  digit;
  logic        cut_mode, spark_inh, force_ang, armed, flash, err_ind, store;
  logic [31:0] seed;
  int          n_fail, tests_run, n_store, n_err, exp_lim, exp_mode, exp_ang, exp_store, exp_err;

  eslm_top #(.PW(24), .TICKS(16)) dut (
    .SYS_CLK(clk), .ARST_N(arst_n), .CE(ce), .MENU_ENTER(menu_enter),
    .SWITCH_PULSE(sw_pulse), .REV_PULSE(rev_pulse), .PERIOD(period),
    .LIMIT_PERIOD(limit_period), .SPEED_LIMIT_VALUE(lim), .CUT_MODE(cut_mode),
    .CUT_ANGLE_DEG(cut_ang), .SPARK_INHIBIT(spark_inh), .FORCE_ANGLE(force_ang),
    .ARMED(armed), .DISP_GLYPH(glyph), .DISP_DIGIT(digit), .DISP_FLASH(flash),
    .ENTRY_ERROR_INDICATION(err_ind), .STORE_STROBE(store));

  eslm_partner u_op (
    .clk(clk), .lim(lim), .glyph(glyph), .digit(digit), .flash(flash),
    .menu_enter(menu_enter), .sw_pulse(sw_pulse), .limit_period(limit_period));

  // ************************************************************
  // clock, counters and helpers
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // store pulses and error displays seen at the ports
  always @(posedge clk) if (store === 1'b1) n_store++;
  always @(posedge err_ind) n_err++;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wait_armed(input logic v);
    for (int n = 0; n < 4000; n++) begin
      @(posedge clk);
      #1;
      if (armed === v) break;
    end
    chk("armed", 32'(armed), 32'(v));
  endtask

  task automatic do_reset();
    #2 arst_n = 1'b0;
    repeat (12) @(posedge clk);
    #2 arst_n = 1'b1;
    repeat (4) @(posedge clk);
    exp_lim = 599;
    exp_mode = 0;
    chk("limit", 32'(lim), 32'(exp_lim));
    chk("mode", 32'(cut_mode), 32'(CUT_SUPPRESS));
    chk("armed", 32'(armed), 32'h1);
  endtask

  // random revolutions around the limit, half of them over it
  task automatic spin(input int n);
    int lp;
    bit ov;
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      lp = 600000 / exp_lim;
      @(posedge clk);
      #2 rev_pulse = 1'b1;
      period = 24'(seed % (2 * lp));
      @(posedge clk);
      #2 rev_pulse = 1'b0;
      repeat (2) @(posedge clk);
      #1 ov = period < lp;
      chk("inhibit", 32'(spark_inh), 32'(ov && exp_mode == 0));
      chk("force", 32'(force_ang), 32'(ov && exp_mode == 1));
    end
  endtask

  // one programming pass; af picks the angle before the limit
  task automatic session(input bit af, input int a, input int b, input int c,
                         input bit no, input int t, input int u);
    int s;
    int ang;
    bit ok;
    s = a * 100 + b * 10 + c;
    ang = t * 10 + u;
    ok = s >= 10 && s <= 599 && (no || ang <= 39);
    u_op.enter();
    for (int k = 0; k < 2; k++) begin
      if ((k == 0) != af) begin
        u_op.act(GLYPH_SEL_LIM, 4'h0);
        u_op.act(GLYPH_DIGIT, 4'(a));
        u_op.act(GLYPH_DIGIT, 4'(b));
        u_op.act(GLYPH_DIGIT, 4'(c));
      end else begin
        u_op.act(GLYPH_SEL_ANG, 4'h0);
        if (no) u_op.act(GLYPH_NO, 4'h0);
        else begin
          u_op.act(GLYPH_DIGIT, 4'(t));
          u_op.act(GLYPH_DIGIT, 4'(u));
        end
      end
    end
    wait_armed(1'b1);
    if (ok) begin
      exp_lim = s;
      exp_mode = no ? 0 : 1;
      exp_ang = ang;
      exp_store++;
    end else exp_err++;
    chk("armed", 32'(armed), 32'h1);
    chk("limit", 32'(lim), 32'(exp_lim));
    chk("mode", 32'(cut_mode), 32'(exp_mode));
    if (exp_mode == 1) chk("angle", 32'(cut_ang), 32'(exp_ang));
    chk("stores", 32'(n_store), 32'(exp_store));
    chk("errors", 32'(n_err), 32'(exp_err));
    spin(8);
  endtask

  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial begin
    {n_fail, tests_run, n_store, n_err, exp_store, exp_err, exp_ang} = '0;
    seed = 32'h8C739D73;
    arst_n = 1'b0;
    ce = 1'b1;
    rev_pulse = 1'b0;
    period = 24'h000000;
    do_reset();
    spin(16);
    session(1'b0, 2, 1, 5, 1'b0, 0, 5);
    session(1'b1, 0, 0, 9, 1'b1, 0, 0);
    session(1'b0, 5, 9, 9, 1'b1, 0, 0);
    session(1'b1, 0, 1, 0, 1'b0, 3, 9);
    session(1'b0, 1, 0, 0, 1'b0, 4, 0);
    // idle pass through the menu leaves every setting alone
    u_op.enter();
    wait_armed(1'b0);
    chk("figure", 32'(digit), 32'(exp_lim / 100));
    #1 ce = 1'b0;
    repeat (40) @(posedge clk);
    #1 chk("frozen", 32'(digit), 32'(exp_lim / 100));
    #1 ce = 1'b1;
    wait_armed(1'b1);
    chk("limit", 32'(lim), 32'(exp_lim));
    chk("stores", 32'(n_store), 32'(exp_store));
    do_reset();
    spin(16);
    report_and_stop();
  end

  initial begin
    #(25ns * 40000);
    n_fail++;
    report_and_stop();
  end
endmodule

// ===== src/eslm_limiter.sv
// module: per-revolution over-speed decision for the ignition path
`timescale 1ns/1ps
module eslm_limiter
  import eslm_pkg::*;
#(
  parameter int unsigned PW = 24
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          ce,
  input  wire logic          rev_pulse,
  input  wire logic [PW-1:0] period,
  input  wire logic [PW-1:0] limit_period,
  output logic               over_reg
);
  // shorter period means faster engine; sampled once per revolution
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      over_reg <= 1'b0;
    end else if (ce && rev_pulse) begin
      over_reg <= (period < limit_period);
    end
  end
endmodule

// ===== src/eslm_timer.sv
// module: 3 s step timer producing one-cycle ticks
`timescale 1ns/1ps
module eslm_timer
  import eslm_pkg::*;
#(
  parameter int unsigned TICKS = STEP_TICKS
) (
  input  wire logic    clk,
  input  wire logic    rst_n,
  input  wire logic    ce,
  eslm_tick_if.timer   tif
);
  logic [31:0] cnt_reg;

  // restart on a switch actuation aligns the option shown next to a full step
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg  <= 32'h0;
      tif.tick <= 1'b0;
    end else if (ce) begin
      tif.tick <= 1'b0;
      if (tif.restart) begin
        cnt_reg <= 32'h0;
      end else if (cnt_reg == 32'(TICKS - 1)) begin
        cnt_reg  <= 32'h0;
        tif.tick <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 32'h1;
      end
    end
  end
endmodule

// ===== src/eslm_top.sv
// module: speed limiter with single-switch programming menu
`timescale 1ns/1ps
module eslm_top
  import eslm_pkg::*;
#(
  parameter int unsigned PW    = 24,
  parameter int unsigned TICKS = STEP_TICKS
) (
  input  wire logic          SYS_CLK,
  input  wire logic          ARST_N,
  input  wire logic          CE,
  input  wire logic          MENU_ENTER,
  input  wire logic          SWITCH_PULSE,
  input  wire logic          REV_PULSE,
  input  wire logic [PW-1:0] PERIOD,
  input  wire logic [PW-1:0] LIMIT_PERIOD,
  output logic [9:0]         SPEED_LIMIT_VALUE,
  output logic               CUT_MODE,
  output logic [5:0]         CUT_ANGLE_DEG,
  output logic               SPARK_INHIBIT,
  output logic               FORCE_ANGLE,
  output logic               ARMED,
  output logic [7:0]         DISP_GLYPH,
  output logic [3:0]         DISP_DIGIT,
  output logic               DISP_FLASH,
  output logic               ENTRY_ERROR_INDICATION,
  output logic               STORE_STROBE
);
  // ************************************************************
  // reset release
  // ************************************************************
  logic rst_s1_reg;
  logic rst_n_reg;

  // two-stage release so the whole design leaves reset on one edge
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg  <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg  <= rst_s1_reg;
    end
  end

  // ************************************************************
  // sub-blocks
  // ************************************************************
  eslm_tick_if tif ();
  logic        over_reg;

  eslm_timer #(.TICKS(TICKS)) u_timer (
    .clk   (SYS_CLK),
    .rst_n (rst_n_reg),
    .ce    (CE),
    .tif   (tif)
  );

  eslm_limiter #(.PW(PW)) u_lim (
    .clk          (SYS_CLK),
    .rst_n        (rst_n_reg),
    .ce           (CE),
    .rev_pulse    (REV_PULSE),
    .period       (PERIOD),
    .limit_period (LIMIT_PERIOD),
    .over_reg     (over_reg)
  );

  // ************************************************************
  // menu state
  // ************************************************************
  eslm_state_e state_reg;
  logic [3:0]  cand_reg;      // candidate now flashing
  logic [3:0]  show_idx_reg;  // digit index while showing values
  logic [3:0]  d_tth_reg;
  logic [3:0]  d_th_reg;
  logic [3:0]  d_h_reg;
  logic [3:0]  a_tens_reg;
  logic        lim_done_reg;  // limit already entered in this session
  logic        ang_done_reg;
  logic        new_lim_reg;
  logic        new_ang_reg;
  logic        new_mode_reg;
  logic [5:0]  new_deg_reg;
  logic        err_reg;
  logic [9:0]  entered;

  assign entered     = eslm_steps(d_tth_reg, d_th_reg, d_h_reg);
  assign tif.restart = SWITCH_PULSE && (state_reg != ESLM_NORMAL);

  // menu sequencer; every option advances on the 3 s tick
  always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg    <= ESLM_NORMAL;
      cand_reg     <= 4'h0;
      show_idx_reg <= 4'h0;
      d_tth_reg    <= 4'h0;
      d_th_reg     <= 4'h0;
      d_h_reg      <= 4'h0;
      a_tens_reg   <= 4'h0;
      lim_done_reg <= 1'b0;
      ang_done_reg <= 1'b0;
      new_lim_reg  <= 1'b0;
      new_ang_reg  <= 1'b0;
      new_mode_reg <= CUT_SUPPRESS;
      new_deg_reg  <= 6'h00;
      err_reg      <= 1'b0;
    end else if (CE) begin
      case (state_reg)
        ESLM_NORMAL: begin
          if (MENU_ENTER) begin
            state_reg    <= ESLM_SHOW_LIM;
            show_idx_reg <= 4'h0;
            lim_done_reg <= 1'b0;
            ang_done_reg <= 1'b0;
            new_lim_reg  <= 1'b0;
            new_ang_reg  <= 1'b0;
            err_reg      <= 1'b0;
          end
        end
        ESLM_SHOW_LIM: begin
          // five figures of the limit, one per step
          if (tif.tick) begin
            if (show_idx_reg == 4'h4) begin
              state_reg <= ESLM_SHOW_ANG;
            end else begin
              show_idx_reg <= show_idx_reg + 4'h1;
            end
          end
        end
        ESLM_SHOW_ANG: begin
          if (tif.tick) begin
            state_reg <= ESLM_PROMPT;
          end
        end
        ESLM_PROMPT: begin
          if (tif.tick) begin
            state_reg <= ESLM_PICK;
            cand_reg  <= 4'h0;
          end
        end
        ESLM_PICK: begin
          // cand 0 = limit, 1 = angle
          if (SWITCH_PULSE) begin
            state_reg <= (cand_reg == 4'h0) ? ESLM_D_TTH : ESLM_A_TENS;
            cand_reg  <= (cand_reg == 4'h0) ? 4'h0 : TENS_NO_CODE;
          end else if (tif.tick) begin
            if (cand_reg == 4'h1) begin
              state_reg <= ESLM_NORMAL;
            end else begin
              cand_reg <= 4'h1;
            end
          end
        end
        ESLM_D_TTH: begin
          if (SWITCH_PULSE) begin
            d_tth_reg <= cand_reg;
            cand_reg  <= 4'h0;
            state_reg <= ESLM_D_TH;
          end else if (tif.tick) begin
            if (cand_reg == TTHOU_LAST) state_reg <= ESLM_NORMAL;
            cand_reg <= eslm_next_digit(cand_reg, TTHOU_LAST);
          end
        end
        ESLM_D_TH: begin
          if (SWITCH_PULSE) begin
            d_th_reg  <= cand_reg;
            cand_reg  <= 4'h0;
            state_reg <= ESLM_D_H;
          end else if (tif.tick) begin
            if (cand_reg == DIGIT_LAST) state_reg <= ESLM_NORMAL;
            cand_reg <= eslm_next_digit(cand_reg, DIGIT_LAST);
          end
        end
        ESLM_D_H: begin
          if (SWITCH_PULSE) begin
            d_h_reg      <= cand_reg;
            lim_done_reg <= 1'b1;
            new_lim_reg  <= 1'b1;
            state_reg    <= ang_done_reg ? ESLM_CHECK : ESLM_PICK2;
          end else if (tif.tick) begin
            if (cand_reg == DIGIT_LAST) state_reg <= ESLM_NORMAL;
            cand_reg <= eslm_next_digit(cand_reg, DIGIT_LAST);
          end
        end
        ESLM_PICK2: begin
          // one remaining parameter, one 3 s step, else go check
          if (SWITCH_PULSE) begin
            state_reg <= lim_done_reg ? ESLM_A_TENS : ESLM_D_TTH;
            cand_reg  <= lim_done_reg ? TENS_NO_CODE : 4'h0;
          end else if (tif.tick) begin
            state_reg <= ESLM_CHECK;
          end
        end
        ESLM_A_TENS: begin
          if (SWITCH_PULSE) begin
            if (cand_reg == TENS_NO_CODE) begin
              new_mode_reg <= CUT_SUPPRESS;
              new_ang_reg  <= 1'b1;
              ang_done_reg <= 1'b1;
              state_reg    <= lim_done_reg ? ESLM_CHECK : ESLM_PICK2;
            end else begin
              a_tens_reg <= cand_reg;
              cand_reg   <= 4'h0;
              state_reg  <= ESLM_A_UNIT;
            end
          end else if (tif.tick) begin
            // order: no, 0..9
            if (cand_reg == DIGIT_LAST) begin
              state_reg <= ESLM_NORMAL;
            end
            cand_reg <= (cand_reg == TENS_NO_CODE) ? 4'h0
                        : eslm_next_digit(cand_reg, DIGIT_LAST);
          end
        end
        ESLM_A_UNIT: begin
          if (SWITCH_PULSE) begin
            new_mode_reg <= CUT_ANGLE;
            new_deg_reg  <= 6'(a_tens_reg) * 6'h0A + 6'(cand_reg);
            new_ang_reg  <= 1'b1;
            ang_done_reg <= 1'b1;
            state_reg    <= lim_done_reg ? ESLM_CHECK : ESLM_PICK2;
          end else if (tif.tick) begin
            if (cand_reg == DIGIT_LAST) state_reg <= ESLM_NORMAL;
            cand_reg <= eslm_next_digit(cand_reg, DIGIT_LAST);
          end
        end
        ESLM_CHECK: begin
          // a tens of 4..9 gives an angle above 39 and is also rejected
          err_reg <= (new_lim_reg && (entered < LIM_MIN_STEPS || entered > LIM_MAX_STEPS))
                     || (new_ang_reg && new_mode_reg == CUT_ANGLE
                         && (a_tens_reg > 4'(ANG_MAX_DEG / 6'h0A)
                             || new_deg_reg > ANG_MAX_DEG));
          state_reg    <= ESLM_ERROR;
          show_idx_reg <= 4'h0;
        end
        ESLM_ERROR: begin
          // error step is skipped by a single cycle when all is well
          if (!err_reg || tif.tick) begin
            state_reg <= ESLM_RES_LIM;
          end
        end
        ESLM_RES_LIM: begin
          if (tif.tick) begin
            if (show_idx_reg == 4'h4) begin
              state_reg <= ESLM_RES_ANG;
            end else begin
              show_idx_reg <= show_idx_reg + 4'h1;
            end
          end
        end
        ESLM_RES_ANG: begin
          if (tif.tick) begin
            state_reg <= err_reg ? ESLM_NORMAL : ESLM_STORED;
          end
        end
        ESLM_STORED: begin
          if (tif.tick) begin
            state_reg <= ESLM_NORMAL;
          end
        end
        default: begin
          state_reg <= ESLM_NORMAL;
        end
      endcase
    end
  end

  // ************************************************************
  // stored settings
  // ************************************************************
  logic commit;
  assign commit = (state_reg == ESLM_ERROR) && !err_reg && (new_lim_reg || new_ang_reg);

  // commit happens after check; the store strobe tells persistence to write
  always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      SPEED_LIMIT_VALUE <= LIM_RESET_STEPS;
      CUT_MODE          <= CUT_SUPPRESS;
      CUT_ANGLE_DEG     <= 6'h00;
      STORE_STROBE      <= 1'b0;
    end else if (CE) begin
      STORE_STROBE <= 1'b0;
      if (commit) begin
        STORE_STROBE <= 1'b1;
        if (new_lim_reg) begin
          SPEED_LIMIT_VALUE <= entered;
        end
        if (new_ang_reg) begin
          CUT_MODE      <= new_mode_reg;
          CUT_ANGLE_DEG <= new_deg_reg;
        end
      end
    end
  end

  // ************************************************************
  // ignition control
  // ************************************************************
  // ignition is disarmed while the operator is in the menu
  always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      SPARK_INHIBIT <= 1'b0;
      FORCE_ANGLE   <= 1'b0;
      ARMED         <= 1'b0;
    end else if (CE) begin
      ARMED         <= (state_reg == ESLM_NORMAL);
      SPARK_INHIBIT <= over_reg && CUT_MODE == CUT_SUPPRESS;
      FORCE_ANGLE   <= over_reg && CUT_MODE == CUT_ANGLE;
    end
  end

  // ************************************************************
  // display
  // ************************************************************
  logic [3:0] shown_digit;
  logic [3:0] lim_tth;
  logic [3:0] lim_th;
  logic [3:0] lim_h;

  assign lim_tth = 4'(SPEED_LIMIT_VALUE / 10'h064);
  assign lim_th  = 4'((SPEED_LIMIT_VALUE / 10'h00A) % 10'h00A);
  assign lim_h   = 4'(SPEED_LIMIT_VALUE % 10'h00A);

  // figure of the stored limit; last two figures are always zero
  always_comb begin
    case (show_idx_reg)
      4'h0:    shown_digit = lim_tth;
      4'h1:    shown_digit = lim_th;
      4'h2:    shown_digit = lim_h;
      default: shown_digit = 4'h0;
    endcase
  end

  // display and indication flags registered straight from state
  always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      DISP_GLYPH             <= GLYPH_SPEED;
      DISP_DIGIT             <= BLANK_CODE;
      DISP_FLASH             <= 1'b0;
      ENTRY_ERROR_INDICATION <= 1'b0;
    end else if (CE) begin
      DISP_FLASH             <= 1'b0;
      DISP_DIGIT             <= BLANK_CODE;
      ENTRY_ERROR_INDICATION <= 1'b0;
      case (state_reg)
        ESLM_SHOW_LIM, ESLM_RES_LIM: begin
          DISP_GLYPH <= GLYPH_DIGIT;
          DISP_DIGIT <= shown_digit;
        end
        ESLM_SHOW_ANG, ESLM_RES_ANG: begin
          DISP_GLYPH <= (CUT_MODE == CUT_SUPPRESS) ? GLYPH_NO : GLYPH_DIGIT;
          DISP_DIGIT <= (CUT_MODE == CUT_SUPPRESS) ? BLANK_CODE : 4'(CUT_ANGLE_DEG % 6'h0A);
        end
        ESLM_PROMPT: DISP_GLYPH <= GLYPH_PROMPT;
        ESLM_PICK: begin
          DISP_GLYPH <= (cand_reg == 4'h0) ? GLYPH_SEL_LIM : GLYPH_SEL_ANG;
          DISP_FLASH <= 1'b1;
        end
        ESLM_PICK2: begin
          DISP_GLYPH <= lim_done_reg ? GLYPH_SEL_ANG : GLYPH_SEL_LIM;
          DISP_FLASH <= 1'b1;
        end
        ESLM_D_TTH, ESLM_D_TH, ESLM_D_H, ESLM_A_UNIT: begin
          DISP_GLYPH <= GLYPH_DIGIT;
          DISP_DIGIT <= cand_reg;
          DISP_FLASH <= 1'b1;
        end
        ESLM_A_TENS: begin
          DISP_GLYPH <= (cand_reg == TENS_NO_CODE) ? GLYPH_NO : GLYPH_DIGIT;
          DISP_DIGIT <= (cand_reg == TENS_NO_CODE) ? BLANK_CODE : cand_reg;
          DISP_FLASH <= 1'b1;
        end
        ESLM_ERROR: begin
          DISP_GLYPH             <= err_reg ? GLYPH_ERROR : GLYPH_DIGIT;
          ENTRY_ERROR_INDICATION <= err_reg;
        end
        ESLM_STORED: DISP_GLYPH <= GLYPH_STORED;
        ESLM_NORMAL: DISP_GLYPH <= GLYPH_SPEED;
        default:     DISP_GLYPH <= GLYPH_SPEED;
      endcase
    end
  end
endmodule
